// >>> src/twbpe_device.sv
// device end: bus master with arbitration plus receiving slave
// Contract
// (RQ1) address packet: seven address, direction, acknowledge
// (RQ2) direction one reads, zero writes
// (RQ3) addressed slave pulls SDA low ninth slot
// (RQ4) unable slave leaves SDA high; STOP follows
// (RQ5) address byte goes most significant first
// (RQ6) enabled slaves acknowledge general call, receive data
// (RQ7) never send general call with read; master does not block it and sends whatever cmd_read gives
// (RQ8) addresses 1111xxx reserved, never acknowledged
// (RQ9) data packet: eight bits then acknowledge
// (RQ10) master clocks; receiver drives acknowledge slot
// (RQ11) receiver NACKs last or refused byte
// (RQ12) START, address, data packets, STOP; never empty
// (RQ13) slave may stretch SCL low; master waits
// (RQ14) SCL phases timed from observed line edges
// (RQ15) lose only when released high reads low
// (RQ16) on loss release SDA, become slave
// (RQ17) arbitration continues bit by bit into data
// (RQ18) all masters use identical packet composition
// (RQ19) START/STOP while SCL high; busy between
// (RQ20) SDA stable while SCL high
// (RQ21) report arbitration loss and not-acknowledge
// (RQ22) open-drain only; inputs synchronised first
`timescale 1ns/1ps
`include "twbpe_defs.svh"
module twbpe_device #(
    parameter logic [6:0] OWN_ADDR = 7'h2A,
    parameter logic       GCALL_EN = 1'b1
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       link_clk,
    twbpe_bus_if.dev        bus,
    input  wire logic       cmd_start,
    input  wire logic [6:0] cmd_addr,
    input  wire logic       cmd_read,
    input  wire logic [7:0] cmd_wdata,
    output logic            cmd_busy,
    output logic            done,
    output logic [7:0]      rdata,
    output logic            nack,
    output logic            arb_lost,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_gcall
);
    localparam logic [7:0] LOW_LAST  = 8'(`TWBPE_SCL_LOW_CYC - 1);
    localparam logic [7:0] LOW_MID   = 8'(`TWBPE_SCL_LOW_CYC / 2);
    localparam logic [7:0] HIGH_LAST = 8'(`TWBPE_SCL_HIGH_CYC - 1);
    localparam logic [7:0] FREE_LAST = 8'(`TWBPE_BUS_FREE_CYC - 1);

    // ---- ref_clk side: command hold and result capture ----
    logic       req_tgl;
    logic [6:0] c_addr;
    logic       c_read;
    logic [7:0] c_wdata;
    logic       done_s1, done_s2, done_s3;
    logic       rx_s1, rx_s2, rx_s3;
    // link side registers read here only after their toggle is seen
    logic       m_done_tgl;
    logic [7:0] m_rdata;
    logic       m_nack;
    logic       m_lost;
    logic       s_rx_tgl;
    logic [7:0] s_rx_data;
    logic       s_gc;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            req_tgl  <= 1'b0;
            c_addr   <= 7'h00;
            c_read   <= 1'b0;
            c_wdata  <= 8'h00;
            cmd_busy <= 1'b0;
        end else if (cmd_start && !cmd_busy) begin
            c_addr   <= cmd_addr;
            c_read   <= cmd_read; // RQ2
            c_wdata  <= cmd_wdata;
            req_tgl  <= !req_tgl;
            cmd_busy <= 1'b1;
        end else if (done_s2 != done_s3) begin
            cmd_busy <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            {done_s1, done_s2, done_s3} <= 3'h0;
            {rx_s1, rx_s2, rx_s3}       <= 3'h0;
            done     <= 1'b0;
            rdata    <= 8'h00;
            nack     <= 1'b0;
            arb_lost <= 1'b0;
            rx_valid <= 1'b0;
            rx_data  <= 8'h00;
            rx_gcall <= 1'b0;
        end else begin
            {done_s1, done_s2, done_s3} <= {m_done_tgl, done_s1, done_s2};
            {rx_s1, rx_s2, rx_s3}       <= {s_rx_tgl, rx_s1, rx_s2};
            done     <= done_s2 != done_s3;
            rx_valid <= rx_s2 != rx_s3;
            if (done_s2 != done_s3) begin
                rdata    <= m_rdata;
                nack     <= m_nack; // RQ21
                arb_lost <= m_lost; // RQ21
            end
            if (rx_s2 != rx_s3) begin
                rx_data  <= s_rx_data;
                rx_gcall <= s_gc;
            end
        end
    end

    // ---- link_clk side ----
    logic lrst_s1, lrst;
    logic scl_s1, scl_s, scl_p;
    logic sda_s1, sda_s, sda_p;
    logic req_s1, req_s2, req_seen;
    logic bus_busy;

    always_ff @(posedge link_clk) begin
        lrst_s1 <= rst;
        lrst    <= lrst_s1;
    end

    always_ff @(posedge link_clk) begin
        if (lrst) begin
            {scl_s1, scl_s, scl_p} <= 3'h7;
            {sda_s1, sda_s, sda_p} <= 3'h7;
            {req_s1, req_s2}       <= 2'h0;
        end else begin
            {scl_s1, scl_s, scl_p} <= {bus.scl, scl_s1, scl_s}; // RQ22
            {sda_s1, sda_s, sda_p} <= {bus.sda, sda_s1, sda_s}; // RQ22
            {req_s1, req_s2}       <= {req_tgl, req_s1};
        end
    end

    wire start_seen = scl_s && scl_p && sda_p && !sda_s;
    wire stop_seen  = scl_s && scl_p && !sda_p && sda_s;
    wire scl_rise   = scl_s && !scl_p;
    wire scl_fall   = !scl_s && scl_p;

    always_ff @(posedge link_clk) begin
        if (lrst)
            bus_busy <= 1'b0;
        else if (start_seen)
            bus_busy <= 1'b1; // RQ19
        else if (stop_seen)
            bus_busy <= 1'b0; // RQ19
    end

    // level of slot: 1 means released
    function automatic logic slot_bit(input logic [4:0] slot, input logic [6:0] a,
                                      input logic rd, input logic [7:0] d);
        if (slot < 5'd7)
            return a[3'(5'd6 - slot)]; // RQ5
        else if (slot == 5'd7)
            return rd; // RQ1
        else if (slot == `TWBPE_ADDR_ACK_SLOT)
            return 1'b1; // RQ10
        else if (slot < `TWBPE_DATA_ACK_SLOT)
            return rd ? 1'b1 : d[3'(5'd16 - slot)]; // RQ9
        else
            return 1'b1; // RQ11
    endfunction

    function automatic logic slot_driven(input logic [4:0] slot, input logic rd);
        return (slot < `TWBPE_ADDR_ACK_SLOT)
            || (!rd && slot > `TWBPE_ADDR_ACK_SLOT && slot < `TWBPE_DATA_ACK_SLOT);
    endfunction

    twbpe_pkg::twbpe_mst_t mst;
    logic [7:0] m_cnt;
    logic [4:0] m_slot;
    logic [6:0] m_addr;
    logic       m_read;
    logic [7:0] m_wdata;
    logic       m_scl_low;
    logic       m_sda_low;

    always_ff @(posedge link_clk) begin
        if (lrst) begin
            mst        <= twbpe_pkg::TWBPE_M_IDLE;
            m_cnt      <= 8'h00;
            m_slot     <= 5'h00;
            m_addr     <= 7'h00;
            m_read     <= 1'b0;
            m_wdata    <= 8'h00;
            m_rdata    <= 8'h00;
            m_nack     <= 1'b0;
            m_lost     <= 1'b0;
            m_done_tgl <= 1'b0;
            m_scl_low  <= 1'b0;
            m_sda_low  <= 1'b0;
            req_seen   <= 1'b0;
        end else begin
            case (mst)
                twbpe_pkg::TWBPE_M_IDLE: begin
                    if (req_s2 != req_seen && !bus_busy) begin
                        req_seen  <= req_s2;
                        m_addr    <= c_addr;
                        m_read    <= c_read;
                        m_wdata   <= c_wdata;
                        m_nack    <= 1'b0;
                        m_lost    <= 1'b0;
                        m_rdata   <= 8'h00;
                        m_cnt     <= 8'h00;
                        m_sda_low <= 1'b1; // RQ19
                        mst       <= twbpe_pkg::TWBPE_M_START;
                    end
                end
                twbpe_pkg::TWBPE_M_START: begin
                    m_cnt <= m_cnt + 8'h01;
                    if (m_cnt == HIGH_LAST) begin
                        m_cnt     <= 8'h00;
                        m_slot    <= 5'h00;
                        m_scl_low <= 1'b1;
                        mst       <= twbpe_pkg::TWBPE_M_LOW;
                    end
                end
                twbpe_pkg::TWBPE_M_LOW: begin
                    m_cnt <= m_cnt + 8'h01;
                    if (m_cnt == LOW_MID) begin
                        // data moves only mid low phase
                        if (m_slot == `TWBPE_STOP_SLOT)
                            m_sda_low <= 1'b1; // RQ20
                        else
                            m_sda_low <= !slot_bit(m_slot, m_addr, m_read, m_wdata); // RQ20
                    end
                    if (m_cnt == LOW_LAST) begin
                        m_cnt     <= 8'h00;
                        m_scl_low <= 1'b0;
                        mst       <= twbpe_pkg::TWBPE_M_WAITH;
                    end
                end
                twbpe_pkg::TWBPE_M_WAITH: begin
                    // stretched low by another party holds us here
                    if (scl_s) begin
                        m_cnt <= 8'h00;
                        mst   <= twbpe_pkg::TWBPE_M_HIGH; // RQ13
                    end
                end
                twbpe_pkg::TWBPE_M_HIGH: begin
                    m_cnt <= m_cnt + 8'h01;
                    if (m_cnt == 8'h01 && m_slot != `TWBPE_STOP_SLOT
                        && slot_driven(m_slot, m_read)
                        && slot_bit(m_slot, m_addr, m_read, m_wdata) && !sda_s) begin
                        // lost: release both lines, the slave side takes over
                        m_lost     <= 1'b1; // RQ15
                        m_sda_low  <= 1'b0; // RQ16
                        m_scl_low  <= 1'b0;
                        m_done_tgl <= !m_done_tgl;
                        mst        <= twbpe_pkg::TWBPE_M_IDLE; // RQ17
                    end else begin
                        if (m_cnt == 8'h01) begin
                            if (m_slot == `TWBPE_ADDR_ACK_SLOT && sda_s)
                                m_nack <= 1'b1; // RQ4
                            if (m_slot == `TWBPE_DATA_ACK_SLOT && !m_read && sda_s)
                                m_nack <= 1'b1; // RQ11
                            if (m_read && m_slot > `TWBPE_ADDR_ACK_SLOT
                                && m_slot < `TWBPE_DATA_ACK_SLOT)
                                m_rdata <= {m_rdata[6:0], sda_s};
                        end
                        // an early low on the combined line ends our high phase
                        if (m_cnt == HIGH_LAST || (m_cnt > 8'h01 && !scl_s)) begin
                            m_cnt <= 8'h00; // RQ14
                            if (m_slot == `TWBPE_STOP_SLOT) begin
                                m_sda_low <= 1'b0; // RQ12
                                mst       <= twbpe_pkg::TWBPE_M_BUF;
                            end else begin
                                m_scl_low <= 1'b1; // RQ14
                                mst       <= twbpe_pkg::TWBPE_M_LOW;
                                if ((m_slot == `TWBPE_ADDR_ACK_SLOT && m_nack)
                                    || m_slot == `TWBPE_DATA_ACK_SLOT)
                                    m_slot <= `TWBPE_STOP_SLOT; // RQ4
                                else
                                    m_slot <= m_slot + 5'h01;
                            end
                        end
                    end
                end
                twbpe_pkg::TWBPE_M_BUF: begin
                    m_cnt <= m_cnt + 8'h01;
                    if (m_cnt == FREE_LAST) begin
                        m_done_tgl <= !m_done_tgl;
                        mst        <= twbpe_pkg::TWBPE_M_IDLE;
                    end
                end
                default: mst <= twbpe_pkg::TWBPE_M_IDLE;
            endcase
        end
    end

    // ---- receiving slave, also watches while a master contends ----
    logic       s_active;
    logic       s_addr_ph;
    logic [3:0] s_cnt;
    logic [7:0] s_sh;
    logic       s_ack_low;
    wire        m_own = (mst != twbpe_pkg::TWBPE_M_IDLE);

    always_ff @(posedge link_clk) begin
        if (lrst) begin
            s_active  <= 1'b0;
            s_addr_ph <= 1'b0;
            s_cnt     <= 4'h0;
            s_sh      <= 8'h00;
            s_ack_low <= 1'b0;
            s_gc      <= 1'b0;
            s_rx_tgl  <= 1'b0;
            s_rx_data <= 8'h00;
        end else if (start_seen) begin
            s_active  <= 1'b1;
            s_addr_ph <= 1'b1;
            s_cnt     <= 4'h0;
            s_ack_low <= 1'b0;
        end else if (stop_seen) begin
            s_active  <= 1'b0;
            s_ack_low <= 1'b0;
        end else if (s_active) begin
            if (scl_rise) begin
                s_sh  <= {s_sh[6:0], sda_s}; // RQ5
                s_cnt <= s_cnt + 4'h1;
            end else if (scl_fall && s_cnt == 4'h8) begin
                if (!s_addr_ph) begin
                    s_ack_low <= 1'b1; // RQ9
                    s_rx_data <= s_sh;
                    s_rx_tgl  <= !s_rx_tgl;
                end else if (!m_own && twbpe_pkg::twbpe_addr_hit(s_sh, OWN_ADDR, GCALL_EN)) begin
                    s_ack_low <= 1'b1; // RQ3
                    s_gc      <= s_sh[7:1] == `TWBPE_GCALL_ADDR; // RQ6
                end else begin
                    // reads, reserved and foreign addresses stay released
                    s_active <= 1'b0; // RQ8
                end
            end else if (scl_fall && s_cnt == 4'h9) begin
                s_ack_low <= 1'b0;
                s_cnt     <= 4'h0;
                s_addr_ph <= 1'b0; // RQ1
            end
        end
    end

    // open-drain: output level fixed low, enable pulls
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            bus.dev_scl_o  <= 1'b0;
            bus.dev_sda_o  <= 1'b0;
            bus.dev_scl_oe <= 1'b0;
            bus.dev_sda_oe <= 1'b0;
        end else begin
            bus.dev_scl_o  <= 1'b0;
            bus.dev_sda_o  <= 1'b0;
            bus.dev_scl_oe <= m_scl_low; // RQ22
            bus.dev_sda_oe <= m_sda_low || s_ack_low; // RQ22
        end
    end
endmodule

// >>> src/twbpe_defs.svh
// timing counts and field constants of the two-wire protocol engine
`ifndef TWBPE_DEFS_SVH
`define TWBPE_DEFS_SVH

`define TWBPE_ADDR_BITS     7
`define TWBPE_BYTE_BITS     8
`define TWBPE_PKT_SLOTS     9
`define TWBPE_GCALL_ADDR    7'h00
`define TWBPE_RSVD_PREFIX   4'hF
`define TWBPE_STOP_SLOT     5'h12
`define TWBPE_ADDR_ACK_SLOT 5'h08
`define TWBPE_DATA_ACK_SLOT 5'h11

`define TWBPE_LINK_NS       12
`define TWBPE_SCL_LOW_NS    1300
`define TWBPE_SCL_HIGH_NS   600
`define TWBPE_BUS_FREE_NS   1300
`define TWBPE_STRETCH_NS    2400
`define TWBPE_SCL_LOW_CYC   ((`TWBPE_SCL_LOW_NS + `TWBPE_LINK_NS - 1) / `TWBPE_LINK_NS)
`define TWBPE_SCL_HIGH_CYC  ((`TWBPE_SCL_HIGH_NS + `TWBPE_LINK_NS - 1) / `TWBPE_LINK_NS)
`define TWBPE_BUS_FREE_CYC  ((`TWBPE_BUS_FREE_NS + `TWBPE_LINK_NS - 1) / `TWBPE_LINK_NS)
`define TWBPE_STRETCH_CYC   ((`TWBPE_STRETCH_NS + `TWBPE_LINK_NS - 1) / `TWBPE_LINK_NS)

`endif

// >>> src/twbpe_pkg.sv
// types and shared address decode of the two-wire protocol engine
`include "twbpe_defs.svh"
package twbpe_pkg;

    typedef enum logic [2:0] {
        TWBPE_M_IDLE,
        TWBPE_M_START,
        TWBPE_M_LOW,
        TWBPE_M_WAITH,
        TWBPE_M_HIGH,
        TWBPE_M_BUF
    } twbpe_mst_t;

    // own address or enabled general call, write only, never reserved
    function automatic logic twbpe_addr_hit(input logic [7:0] pkt,
                                            input logic [6:0] own,
                                            input logic       gc_en);
        logic own_hit;
        logic gc_hit;
        own_hit = (pkt[7:1] == own) && (pkt[7:4] != `TWBPE_RSVD_PREFIX);
        gc_hit  = gc_en && (pkt[7:1] == `TWBPE_GCALL_ADDR);
        return (own_hit || gc_hit) && !pkt[0];
    endfunction

endpackage

// >>> src/twbpe_bus_if.sv
// wired-AND two-wire bus joining the device end and the far end
`timescale 1ns/1ps
interface twbpe_bus_if;
    logic dev_scl_o;
    logic dev_scl_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic far_scl_o;
    logic far_scl_oe;
    logic far_sda_o;
    logic far_sda_oe;
    logic scl;
    logic sda;

    // pull-up unless some driver pulls low
    assign scl = !((dev_scl_oe && !dev_scl_o) || (far_scl_oe && !far_scl_o));
    assign sda = !((dev_sda_oe && !dev_sda_o) || (far_sda_oe && !far_sda_o));

    modport dev (output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe, input scl, sda);
    modport far (output far_scl_o, far_scl_oe, far_sda_o, far_sda_oe, input scl, sda);
endinterface

// >>> src/twbpe_far.sv
// far end: slave on the shared bus with read support and clock stretching
`timescale 1ns/1ps
`include "twbpe_defs.svh"
module twbpe_far #(
    parameter logic [6:0] FAR_ADDR    = 7'h51,
    parameter logic       GCALL_EN    = 1'b1,
    parameter int         STRETCH_CYC = `TWBPE_STRETCH_CYC
) (
    input  wire logic       link_clk,
    input  wire logic       rst,
    twbpe_bus_if.far        bus,
    input  wire logic [7:0] tx_data,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rd_nacked
);
    logic       scl_s1, scl_s, scl_p;
    logic       sda_s1, sda_s, sda_p;
    logic       active;
    logic       addr_ph;
    logic       rd;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx_sh;
    logic       sda_low;
    logic [7:0] hold;
    logic       rst_s1;
    logic       lrst;

    // rst comes from the ref_clk side, so it is resynchronised first
    always_ff @(posedge link_clk) begin
        rst_s1 <= rst;
        lrst   <= rst_s1;
    end

    always_ff @(posedge link_clk) begin
        if (lrst) begin
            {scl_s1, scl_s, scl_p} <= 3'h7;
            {sda_s1, sda_s, sda_p} <= 3'h7;
        end else begin
            {scl_s1, scl_s, scl_p} <= {bus.scl, scl_s1, scl_s};
            {sda_s1, sda_s, sda_p} <= {bus.sda, sda_s1, sda_s};
        end
    end

    wire start_seen = scl_s && scl_p && sda_p && !sda_s;
    wire stop_seen  = scl_s && scl_p && !sda_p && sda_s;
    wire scl_rise   = scl_s && !scl_p;
    wire scl_fall   = !scl_s && scl_p;
    wire addr_ok    = (sh[7:1] == FAR_ADDR) && (sh[7:4] != `TWBPE_RSVD_PREFIX);

    always_ff @(posedge link_clk) begin
        if (lrst) begin
            active    <= 1'b0;
            addr_ph   <= 1'b0;
            rd        <= 1'b0;
            cnt       <= 4'h0;
            sh        <= 8'h00;
            tx_sh     <= 8'h00;
            sda_low   <= 1'b0;
            hold      <= 8'h00;
            rx_valid  <= 1'b0;
            rx_data   <= 8'h00;
            rd_nacked <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (hold != 8'h00)
                hold <= hold - 8'h01;
            if (start_seen) begin
                active  <= 1'b1;
                addr_ph <= 1'b1;
                rd      <= 1'b0;
                cnt     <= 4'h0;
                sda_low <= 1'b0;
            end else if (stop_seen) begin
                active  <= 1'b0;
                sda_low <= 1'b0;
            end else if (active) begin
                if (scl_rise) begin
                    sh  <= {sh[6:0], sda_s};
                    cnt <= cnt + 4'h1;
                    // master's acknowledge after a read byte
                    if (rd && !addr_ph && cnt == 4'h8 && sda_s) begin
                        rd_nacked <= 1'b1;
                        active    <= 1'b0;
                    end
                end else if (scl_fall && cnt == 4'h8) begin
                    if (addr_ph) begin
                        if (addr_ok || twbpe_pkg::twbpe_addr_hit(sh, FAR_ADDR, GCALL_EN)) begin
                            sda_low   <= 1'b1;
                            rd        <= sh[0];
                            rd_nacked <= 1'b0;
                        end else begin
                            active <= 1'b0;
                        end
                    end else if (rd) begin
                        sda_low <= 1'b0;
                    end else begin
                        sda_low  <= 1'b1;
                        rx_data  <= sh;
                        rx_valid <= 1'b1;
                    end
                end else if (scl_fall && cnt == 4'h9) begin
                    cnt     <= 4'h0;
                    addr_ph <= 1'b0;
                    // stretch to give the user side time between bytes
                    hold    <= 8'(STRETCH_CYC);
                    if (rd) begin
                        tx_sh   <= tx_data;
                        sda_low <= !tx_data[7];
                    end else begin
                        sda_low <= 1'b0;
                    end
                end else if (scl_fall && rd && cnt != 4'h0 && cnt < 4'h8) begin
                    sda_low <= !tx_sh[3'(4'h7 - cnt)];
                end
            end
        end
    end

    always_ff @(posedge link_clk) begin
        if (lrst) begin
            bus.far_scl_o  <= 1'b0;
            bus.far_sda_o  <= 1'b0;
            bus.far_scl_oe <= 1'b0;
            bus.far_sda_oe <= 1'b0;
        end else begin
            bus.far_scl_o  <= 1'b0;
            bus.far_sda_o  <= 1'b0;
            bus.far_scl_oe <= hold > 8'h01;
            bus.far_sda_oe <= sda_low;
        end
    end
endmodule

// >>> tb/twbpe_bus_sva.sv
// link-side protocol checks on the shared two-wire bus
`timescale 1ns/1ps
module twbpe_bus_sva #(
    parameter int STRETCH_CYC = 4
) (
    input wire logic link_clk,
    input wire logic rst,
    input wire logic dev_scl_o,
    input wire logic dev_scl_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic far_scl_o,
    input wire logic far_scl_oe,
    input wire logic far_sda_o,
    input wire logic far_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    int unsigned hold_cnt;

    always_ff @(posedge link_clk) begin
        if (rst || !far_scl_oe) begin
            hold_cnt <= 0;
        end else begin
            hold_cnt <= hold_cnt + 1;
        end
    end

    default clocking @(posedge link_clk); endclocking
    default disable iff (rst);

    a_dev_open_drain: assert property (!dev_scl_o && !dev_sda_o)
        else $error("device drives a line high");
    a_far_open_drain: assert property (!far_scl_o && !far_sda_o)
        else $error("far end drives a line high");
    a_far_sda_low: assert property ($changed(far_sda_oe) |-> !$past(scl))
        else $error("far end moved sda while scl high");
    a_far_stretch_low: assert property ($rose(far_scl_oe) |-> !$past(scl))
        else $error("far end cut an scl high phase");
    a_stretch_len: assert property ($fell(far_scl_oe) |-> hold_cnt == STRETCH_CYC - 1)
        else $error("stretch length wrong");
    a_high_min: assert property ($rose(scl) && !far_scl_oe |-> scl [*8])
        else $error("scl high phase too short");
    a_start_hold: assert property ($rose(dev_sda_oe) && $past(scl) |-> scl [*8])
        else $error("start not held with scl high");
    a_start_clock: assert property ($fell(sda) && scl |-> ##[1:80] !scl)
        else $error("no clocking after start");
    a_stop_free: assert property ($rose(sda) && scl && $past(scl) |-> !dev_sda_oe [*8])
        else $error("bus not left free after stop");

    c_stretch: cover property ($fell(far_scl_oe));
    c_far_ack: cover property ($rose(far_sda_oe));
    c_stop: cover property ($rose(sda) && scl);
endmodule

// >>> tb/two_wire_bus_protocol_engine_test.sv
// end-to-end bench: device end as master against the far-end slave
`timescale 1ns/1ps
module two_wire_bus_protocol_engine_test;
    logic       ref_clk;
    logic       link_clk;
    logic       rst;
    logic       cmd_start;
    logic [6:0] cmd_addr;
    logic       cmd_read;
    logic [7:0] cmd_wdata;
    logic [7:0] tx_data;
    logic       done;
    logic       cmd_busy;
    logic       nack;
    logic       arb_lost;
    logic       rd_nacked;
    logic [7:0] rdata;
    logic [7:0] far_rx;
    logic [7:0] wire_byte;
    logic       wire_ack;
    int         bitn;
    int         fails;
    int         comparisons;
    logic [6:0] bad_addr [3] = '{7'h33, 7'h78, 7'h7F};

    twbpe_bus_if bus_if();
    twbpe_device twbpe_device_inst (.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk),
        .bus(bus_if), .cmd_start(cmd_start), .cmd_addr(cmd_addr), .cmd_read(cmd_read),
        .cmd_wdata(cmd_wdata), .cmd_busy(cmd_busy), .done(done), .rdata(rdata), .nack(nack),
        .arb_lost(arb_lost), .rx_valid(), .rx_data(), .rx_gcall());
    // stretch outlasts the master's low phase, so the master really has to wait
    twbpe_far #(.STRETCH_CYC(150)) twbpe_far_inst (.link_clk(link_clk), .rst(rst), .bus(bus_if),
        .tx_data(tx_data), .rx_valid(), .rx_data(far_rx), .rd_nacked(rd_nacked));
    twbpe_bus_sva #(.STRETCH_CYC(150)) twbpe_bus_sva_inst (.link_clk(link_clk), .rst(rst),
        .dev_scl_o(bus_if.dev_scl_o), .dev_scl_oe(bus_if.dev_scl_oe),
        .dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe(bus_if.dev_sda_oe),
        .far_scl_o(bus_if.far_scl_o), .far_scl_oe(bus_if.far_scl_oe),
        .far_sda_o(bus_if.far_sda_o), .far_sda_oe(bus_if.far_sda_oe),
        .scl(bus_if.scl), .sda(bus_if.sda));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // first link edge at 1 ns so reset spans four link edges
    initial begin
        link_clk = 1'b0;
        #1 link_clk = 1'b1;
        forever #6 link_clk = ~link_clk;
    end

    // wire sniffer: first byte and its acknowledge after each start
    always @(negedge bus_if.sda) if (bus_if.scl) bitn = 0;
    always @(posedge bus_if.scl) begin
        if (bitn < 8) wire_byte[7 - bitn] = bus_if.sda;
        if (bitn == 8) wire_ack = bus_if.sda;
        bitn++;
    end

    task automatic give_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] d);
        int n;
        @(posedge ref_clk) #1;
        {cmd_addr, cmd_read, cmd_wdata, cmd_start} = {a, rd, d, 1'b1};
        @(posedge ref_clk) #1 cmd_start = 1'b0;
        chk({7'h00, cmd_busy}, 8'h01);
        for (n = 0; n < 20000 && done !== 1'b1; n++) @(posedge ref_clk) #1;
        // a hung transfer ends the run rather than stalling it
        if (done !== 1'b1) begin
            fails++;
            $display("CHECK FAILED at %0t: transfer timed out", $time);
            give_verdict();
        end
    endtask

    initial begin
        rst = 1'b1;
        {cmd_start, cmd_addr, cmd_read, cmd_wdata} = 17'h0;
        tx_data = 8'h3C;
        {fails, comparisons, bitn} = {32'h0, 32'h0, 32'h63};
        repeat (5) @(posedge ref_clk);
        #1 rst = 1'b0;
        repeat (8) @(posedge ref_clk);
        xfer(7'h51, 1'b0, 8'hA5);
        chk(wire_byte, 8'hA2);
        chk({7'h00, wire_ack}, 8'h00);
        chk({6'h00, nack, arb_lost}, 8'h00);
        chk(far_rx, 8'hA5);
        $display("test write done");
        xfer(7'h51, 1'b1, 8'h00);
        chk(wire_byte, 8'hA3);
        chk(rdata, 8'h3C);
        chk({7'h00, rd_nacked}, 8'h01);
        $display("test read done");
        xfer(7'h00, 1'b0, 8'h5A);
        chk({7'h00, nack}, 8'h00);
        chk(far_rx, 8'h5A);
        $display("test general call done");
        foreach (bad_addr[i]) begin
            xfer(bad_addr[i], 1'b0, 8'hC3);
            chk({6'h00, nack, wire_ack}, 8'h03);
        end
        $display("test refused address done");
        give_verdict();
    end
endmodule
